//--- shared/dmc_pkg.sv
// shared constants for the dual multiply-accumulate coefficient-pair datapath
package dmc_pkg;
	// apb register byte offsets
	localparam logic [7:0] DMC_CTRL_OFF      = 8'h00;
	localparam logic [7:0] DMC_STATUS_OFF    = 8'h04;
	localparam logic [7:0] DMC_ACC1_LO_OFF   = 8'h08;
	localparam logic [7:0] DMC_ACC1_HI_OFF   = 8'h0c;
	localparam logic [7:0] DMC_ACC2_LO_OFF   = 8'h10;
	localparam logic [7:0] DMC_ACC2_HI_OFF   = 8'h14;
	localparam logic [7:0] DMC_OPCOUNT_OFF   = 8'h18;
	// control field positions
	localparam int DMC_CTRL_FRAC_BIT  = 0;
	localparam int DMC_CTRL_MSAT_BIT  = 1;
	localparam int DMC_CTRL_RSTYLE_BIT = 2;
	localparam int DMC_CTRL_WIDE_BIT  = 3;
	localparam int DMC_CTRL_ASAT_BIT  = 4;
	localparam int DMC_CTRL_WIDTH     = 5;
	// status field positions
	localparam int DMC_STAT_OVF1_BIT  = 0;
	localparam int DMC_STAT_OVF2_BIT  = 1;
	// reset values
	localparam logic [4:0]  DMC_CTRL_RESET = 5'h00;
	localparam logic [39:0] DMC_ACC_RESET  = 40'h00_0000_0000;
	// arithmetic constants
	localparam int          DMC_ACC_SHIFT    = 16;
	localparam logic [15:0] DMC_MIN_OPERAND  = 16'h8000;
	localparam logic [31:0] DMC_MUL_SAT_VAL  = 32'h7fff_ffff;
	localparam logic [40:0] DMC_ROUND_ADD    = 41'h0_0000_8000;
	localparam logic [39:0] DMC_SAT40_POS    = 40'h7f_ffff_ffff;
	localparam logic [39:0] DMC_SAT40_NEG    = 40'h80_0000_0000;
	localparam logic [39:0] DMC_SAT32_POS    = 40'h00_7fff_ffff;
	localparam logic [39:0] DMC_SAT32_NEG    = 40'hff_8000_0000;
	// accumulate variants
	typedef enum logic [1:0] {
		DMC_VAR_PLAIN  = 2'b00,
		DMC_VAR_MIXED  = 2'b01,
		DMC_VAR_DOUBLE = 2'b10
	} dmc_variant_e;
endpackage : dmc_pkg

//--- hdl/dmc_mac_unit.sv
// one multiplier-accumulator unit: extension, product, shift, round, overflow, saturation
`timescale 1ns/1ps
module dmc_mac_unit
	import dmc_pkg::*;
(
	// operands
	input  wire logic [15:0] data_op,
	input  wire logic [15:0] coeff_op,
	input  wire logic        uns_data,
	input  wire logic        uns_coeff,
	input  wire logic [39:0] acc_in,
	// per-instruction options
	input  wire logic        shift_acc,
	input  wire logic        round_en,
	input  wire logic        wide_en,
	// control bits
	input  wire logic        frac_en,
	input  wire logic        mul_sat,
	input  wire logic        round_style,
	input  wire logic        acc_sat,
	// result
	output logic      [39:0] acc_out,
	output logic             ovf
);
	logic signed [16:0] ext_data;
	logic signed [16:0] ext_coeff;
	logic signed [33:0] prod;
	logic        [31:0] mres;
	logic        [40:0] src;
	logic        [40:0] sum;
	logic               round_tie;

	always_comb begin
		ext_data  = uns_data ? {1'b0, data_op} : {data_op[15], data_op};
		ext_coeff = uns_coeff ? {1'b0, coeff_op} : {coeff_op[15], coeff_op};
		prod = ext_data * ext_coeff;
		mres = frac_en ? {prod[30:0], 1'b0} : prod[31:0];
		if (mul_sat && frac_en && !uns_data && !uns_coeff &&
				data_op == DMC_MIN_OPERAND && coeff_op == DMC_MIN_OPERAND) begin
			mres = DMC_MUL_SAT_VAL;
		end
		if (shift_acc) begin
			src = {{(DMC_ACC_SHIFT + 1){acc_in[39]}}, acc_in[39:DMC_ACC_SHIFT]};
		end else begin
			src = {acc_in[39], acc_in};
		end
		sum = src + {{9{mres[31]}}, mres};
		round_tie = 1'b0;
		if (round_en) begin
			round_tie = (sum[15:0] == 16'h8000);
			sum = sum + DMC_ROUND_ADD;
			if (round_style && round_tie) begin
				sum[16] = 1'b0;
			end
			sum[15:0] = 16'h0000;
		end
		if (wide_en) begin
			ovf = (sum[40] != sum[39]);
		end else begin
			ovf = !((&sum[40:31]) || !(|sum[40:31]));
		end
		acc_out = sum[39:0];
		if (ovf && acc_sat) begin
			if (wide_en) begin
				acc_out = sum[40] ? DMC_SAT40_NEG : DMC_SAT40_POS;
			end else begin
				acc_out = sum[40] ? DMC_SAT32_NEG : DMC_SAT32_POS;
			end
		end
	end
endmodule : dmc_mac_unit

//--- hdl/dmc_datapath.sv
// dual multiply-accumulate datapath with coefficient pair fetch and apb registers
`timescale 1ns/1ps
module dmc_datapath
	import dmc_pkg::*;
(
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// operation request
	input  wire logic        cmd_valid,
	input  wire logic [1:0]  cmd_variant,
	input  wire logic        cmd_uns_data,
	input  wire logic        cmd_uns_coeff,
	input  wire logic        cmd_round,
	input  wire logic        cmd_wide,
	input  wire logic [23:0] effective_location,
	// coefficient address bus
	output logic             coeff_read,
	output logic      [23:0] coefficient_address_bus,
	output logic      [23:0] coefficient_pair_address,
	// operand read buses, valid in the cycle that coeff_read is high
	input  wire logic [15:0] primary_data_read_bus,
	input  wire logic [15:0] coefficient_high_read_bus,
	input  wire logic [15:0] coefficient_low_read_bus,
	// results
	output logic             mac_done,
	output logic             first_acc_overflow_flag,
	output logic             second_acc_overflow_flag
);
	logic [31:0] prdata_reg;
	logic        pready_reg;
	logic        pslverr_reg;
	logic        coeff_read_reg;
	logic [23:0] high_addr_reg;
	logic [23:0] low_addr_reg;
	logic        mac_done_reg;
	logic [4:0]  ctrl_reg;
	logic        ovf1_reg;
	logic        ovf2_reg;
	logic [39:0] first_accumulator_reg;
	logic [39:0] second_accumulator_reg;
	logic [31:0] opcount_reg;
	dmc_variant_e variant_reg;
	logic        uns_data_reg;
	logic        uns_coeff_reg;
	logic        round_reg;
	logic        wide_reg;

	logic        apb_setup;
	logic        apb_write;
	logic        addr_hit;
	logic [31:0] rd_value;
	logic [39:0] acc_in   [2];
	logic [39:0] acc_res  [2];
	logic        ovf_res  [2];
	logic        shift_en [2];
	logic [15:0] coeff_in [2];
	logic        wide_eff;
	logic [23:0] pair_addr;
	logic        wr_ctrl;
	logic        wr_status;
	logic        wr_acc1_lo;
	logic        wr_acc1_hi;
	logic        wr_acc2_lo;
	logic        wr_acc2_hi;
	logic        wr_opcount;

	assign apb_setup = psel && !penable;
	assign apb_write = psel && penable && pready_reg && pwrite && !pslverr_reg;

	// register write strobes, one per mapped word
	always_comb begin
		wr_ctrl    = 1'b0;
		wr_status  = 1'b0;
		wr_acc1_lo = 1'b0;
		wr_acc1_hi = 1'b0;
		wr_acc2_lo = 1'b0;
		wr_acc2_hi = 1'b0;
		wr_opcount = 1'b0;
		if (apb_write) begin
			case (paddr)
				DMC_CTRL_OFF: begin
					wr_ctrl = 1'b1;
				end
				DMC_STATUS_OFF: begin
					wr_status = 1'b1;
				end
				DMC_ACC1_LO_OFF: begin
					wr_acc1_lo = 1'b1;
				end
				DMC_ACC1_HI_OFF: begin
					wr_acc1_hi = 1'b1;
				end
				DMC_ACC2_LO_OFF: begin
					wr_acc2_lo = 1'b1;
				end
				DMC_ACC2_HI_OFF: begin
					wr_acc2_hi = 1'b1;
				end
				DMC_OPCOUNT_OFF: begin
					wr_opcount = 1'b1;
				end
				default: begin
					wr_ctrl = 1'b0;
				end
			endcase
		end
	end

	always_comb begin
		addr_hit = 1'b1;
		rd_value = 32'h0000_0000;
		case (paddr)
			DMC_CTRL_OFF: begin
				rd_value = {27'h0, ctrl_reg};
			end
			DMC_STATUS_OFF: begin
				rd_value = {30'h0, ovf2_reg, ovf1_reg};
			end
			DMC_ACC1_LO_OFF: begin
				rd_value = first_accumulator_reg[31:0];
			end
			DMC_ACC1_HI_OFF: begin
				rd_value = {24'h00_0000, first_accumulator_reg[39:32]};
			end
			DMC_ACC2_LO_OFF: begin
				rd_value = second_accumulator_reg[31:0];
			end
			DMC_ACC2_HI_OFF: begin
				rd_value = {24'h00_0000, second_accumulator_reg[39:32]};
			end
			DMC_OPCOUNT_OFF: begin
				rd_value = opcount_reg;
			end
			default: begin
				addr_hit = 1'b0;
			end
		endcase
	end

	// apb answer: registered during setup, shown in the one-cycle access phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_reg  <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg  <= 32'h0000_0000;
		end else begin
			pready_reg  <= apb_setup;
			pslverr_reg <= apb_setup && !addr_hit;
			if (apb_setup && !pwrite && addr_hit) begin
				prdata_reg <= rd_value;
			end else if (apb_setup) begin
				prdata_reg <= 32'h0000_0000;
			end
		end
	end

	// control register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_reg <= DMC_CTRL_RESET;
		end else if (wr_ctrl) begin
			ctrl_reg <= pwdata[DMC_CTRL_WIDTH-1:0];
		end
	end

	// address stage: pair address and command capture
	always_comb begin
		if (effective_location[0]) begin
			pair_addr = effective_location - 24'h00_0001;
		end else begin
			pair_addr = effective_location + 24'h00_0001;
		end
	end

	// coefficient addresses, held until the next request
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			high_addr_reg <= 24'h00_0000;
			low_addr_reg  <= 24'h00_0000;
		end else if (cmd_valid) begin
			high_addr_reg <= effective_location;
			low_addr_reg  <= pair_addr;
		end
	end

	// command options, applied in the read cycle that follows
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			coeff_read_reg <= 1'b0;
			variant_reg    <= DMC_VAR_PLAIN;
			uns_data_reg   <= 1'b0;
			uns_coeff_reg  <= 1'b0;
			round_reg      <= 1'b0;
			wide_reg       <= 1'b0;
		end else begin
			coeff_read_reg <= cmd_valid;
			if (cmd_valid) begin
				uns_data_reg  <= cmd_uns_data;
				uns_coeff_reg <= cmd_uns_coeff;
				round_reg     <= cmd_round;
				wide_reg      <= cmd_wide;
				case (cmd_variant)
					DMC_VAR_MIXED: begin
						variant_reg <= DMC_VAR_MIXED;
					end
					DMC_VAR_DOUBLE: begin
						variant_reg <= DMC_VAR_DOUBLE;
					end
					default: begin
						variant_reg <= DMC_VAR_PLAIN;
					end
				endcase
			end
		end
	end

	// execute stage: both units share the single data operand
	assign wide_eff    = ctrl_reg[DMC_CTRL_WIDE_BIT] || wide_reg;
	assign acc_in[0]   = first_accumulator_reg;
	assign acc_in[1]   = second_accumulator_reg;
	assign coeff_in[0] = coefficient_low_read_bus;
	assign coeff_in[1] = coefficient_high_read_bus;
	assign shift_en[0] = (variant_reg == DMC_VAR_MIXED) || (variant_reg == DMC_VAR_DOUBLE);
	assign shift_en[1] = (variant_reg == DMC_VAR_DOUBLE);

	genvar u;
	generate
		for (u = 0; u < 2; u++) begin : g_unit
			dmc_mac_unit u_mac (
				.data_op     (primary_data_read_bus),
				.coeff_op    (coeff_in[u]),
				.uns_data    (uns_data_reg),
				.uns_coeff   (uns_coeff_reg),
				.acc_in      (acc_in[u]),
				.shift_acc   (shift_en[u]),
				.round_en    (round_reg),
				.wide_en     (wide_eff),
				.frac_en     (ctrl_reg[DMC_CTRL_FRAC_BIT]),
				.mul_sat     (ctrl_reg[DMC_CTRL_MSAT_BIT]),
				.round_style (ctrl_reg[DMC_CTRL_RSTYLE_BIT]),
				.acc_sat     (ctrl_reg[DMC_CTRL_ASAT_BIT]),
				.acc_out     (acc_res[u]),
				.ovf         (ovf_res[u])
			);
		end
	endgenerate

	// first accumulator: datapath update wins over a software write
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			first_accumulator_reg <= DMC_ACC_RESET;
		end else if (coeff_read_reg) begin
			first_accumulator_reg <= acc_res[0];
		end else if (wr_acc1_lo) begin
			first_accumulator_reg[31:0] <= pwdata;
		end else if (wr_acc1_hi) begin
			first_accumulator_reg[39:32] <= pwdata[7:0];
		end
	end

	// second accumulator
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			second_accumulator_reg <= DMC_ACC_RESET;
		end else if (coeff_read_reg) begin
			second_accumulator_reg <= acc_res[1];
		end else if (wr_acc2_lo) begin
			second_accumulator_reg[31:0] <= pwdata;
		end else if (wr_acc2_hi) begin
			second_accumulator_reg[39:32] <= pwdata[7:0];
		end
	end

	// sticky overflow flags, write one to clear, a new overflow wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ovf1_reg <= 1'b0;
			ovf2_reg <= 1'b0;
		end else begin
			if (coeff_read_reg && ovf_res[0]) begin
				ovf1_reg <= 1'b1;
			end else if (wr_status && pwdata[DMC_STAT_OVF1_BIT]) begin
				ovf1_reg <= 1'b0;
			end
			if (coeff_read_reg && ovf_res[1]) begin
				ovf2_reg <= 1'b1;
			end else if (wr_status && pwdata[DMC_STAT_OVF2_BIT]) begin
				ovf2_reg <= 1'b0;
			end
		end
	end

	// completion pulse, one cycle after the read cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mac_done_reg <= 1'b0;
		end else begin
			mac_done_reg <= coeff_read_reg;
		end
	end

	// operation count, any write clears it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			opcount_reg <= 32'h0000_0000;
		end else if (wr_opcount) begin
			opcount_reg <= 32'h0000_0000;
		end else if (coeff_read_reg) begin
			opcount_reg <= opcount_reg + 32'h0000_0001;
		end
	end

	assign prdata                   = prdata_reg;
	assign pready                   = pready_reg;
	assign pslverr                  = pslverr_reg;
	assign coeff_read               = coeff_read_reg;
	assign coefficient_address_bus  = high_addr_reg;
	assign coefficient_pair_address = low_addr_reg;
	assign mac_done                 = mac_done_reg;
	assign first_acc_overflow_flag  = ovf1_reg;
	assign second_acc_overflow_flag = ovf2_reg;
endmodule : dmc_datapath

//--- testbench/dmc_datapath_monitor.sv
// port checker for the dual mac datapath
`timescale 1ns/1ps
module dmc_datapath_monitor
	import dmc_pkg::*;
(
	// clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// apb
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pready,
	// operation
	input wire logic        cmd_valid,
	input wire logic [23:0] effective_location,
	input wire logic        coeff_read,
	input wire logic [23:0] coefficient_address_bus,
	input wire logic [23:0] coefficient_pair_address,
	input wire logic        mac_done,
	input wire logic        first_acc_overflow_flag,
	input wire logic        second_acc_overflow_flag
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_read_after_req; cmd_valid |=> coeff_read; endproperty
	a_read_after_req: assert property (p_read_after_req) else $error("no read after request");
	property p_no_stray_read; !cmd_valid |=> !coeff_read; endproperty
	a_no_stray_read: assert property (p_no_stray_read) else $error("read without request");
	property p_done; mac_done == $past(coeff_read); endproperty
	a_done: assert property (p_done) else $error("done not one cycle after read");
	property p_hi_addr; coeff_read |-> coefficient_address_bus == $past(effective_location);
	endproperty
	a_hi_addr: assert property (p_hi_addr) else $error("high address wrong");
	property p_pair_addr; coeff_read |-> coefficient_pair_address ==
		($past(effective_location) ^ 24'h00_0001); endproperty
	a_pair_addr: assert property (p_pair_addr) else $error("pair address wrong");
	property p_flag1; $rose(first_acc_overflow_flag) |-> $past(coeff_read); endproperty
	a_flag1: assert property (p_flag1) else $error("first flag rose without op");
	property p_flag2; $rose(second_acc_overflow_flag) |-> $past(coeff_read); endproperty
	a_flag2: assert property (p_flag2) else $error("second flag rose without op");
	property p_ready; psel && !penable |=> pready; endproperty
	a_ready: assert property (p_ready) else $error("no ready after setup");
endmodule : dmc_datapath_monitor

bind dmc_datapath dmc_datapath_monitor u_mon (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pready(pready), .cmd_valid(cmd_valid),
	.effective_location(effective_location), .coeff_read(coeff_read),
	.coefficient_address_bus(coefficient_address_bus),
	.coefficient_pair_address(coefficient_pair_address), .mac_done(mac_done),
	.first_acc_overflow_flag(first_acc_overflow_flag),
	.second_acc_overflow_flag(second_acc_overflow_flag));

//--- testbench/dmc_mem_model.sv
// internal memory model answering the three read buses
`timescale 1ns/1ps
module dmc_mem_model
	import dmc_pkg::*;
(
	// clock and request
	input  wire logic        pclk,
	input  wire logic        coeff_read,
	input  wire logic [23:0] hi_addr,
	input  wire logic [23:0] lo_addr,
	input  wire logic [15:0] data_word,
	// read buses
	output logic      [15:0] data_bus,
	output logic      [15:0] hi_bus,
	output logic      [15:0] lo_bus
);
	logic [15:0] mem [16];
	logic [47:0] last_reg = 48'h0;
	// words only while the read is open, a toggling pattern otherwise
	always_comb begin
		if (coeff_read) begin
			data_bus = data_word;
			hi_bus   = mem[hi_addr[3:0]];
			lo_bus   = mem[lo_addr[3:0]];
		end else begin
			{data_bus, hi_bus, lo_bus} = ~last_reg;
		end
	end
	always_ff @(posedge pclk) begin
		last_reg <= {data_bus, hi_bus, lo_bus};
	end
endmodule : dmc_mem_model

//--- testbench/testbench.sv
// self-checking bench for the dual mac datapath
`timescale 1ns/1ps
module testbench import dmc_pkg::*;;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
	logic        cv, ud, uc, rn, wd, coeff_read, mac_done, f1, f2, ef1, ef2;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, q, r, seed;
	logic [1:0]  cvar;
	logic [4:0]  ct;
	logic [15:0] dv, dw, db, hb, lb;
	logic [23:0] ea, cab, cpa;
	logic [39:0] e1, e2;
	logic [40:0] r1, r2;
	int          err_count, checks_done, i, k;
	dmc_datapath uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .cmd_valid(cv), .cmd_variant(cvar), .cmd_uns_data(ud),
		.cmd_uns_coeff(uc), .cmd_round(rn), .cmd_wide(wd), .effective_location(ea),
		.coeff_read(coeff_read), .coefficient_address_bus(cab),
		.coefficient_pair_address(cpa), .primary_data_read_bus(db),
		.coefficient_high_read_bus(hb), .coefficient_low_read_bus(lb),
		.mac_done(mac_done), .first_acc_overflow_flag(f1), .second_acc_overflow_flag(f2));
	dmc_mem_model pm (.pclk(pclk), .coeff_read(coeff_read), .hi_addr(cab), .lo_addr(cpa),
		.data_word(dw), .data_bus(db), .hi_bus(hb), .lo_bus(lb));
	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd
	// expected {overflow, accumulator} of one unit
	function automatic logic [40:0] ref_mac(input logic [39:0] a, input logic [15:0] d, c,
			input logic xu, cu, sh, rd_en, wide, input logic [4:0] cf);
		logic signed [16:0] xd, xc;
		logic signed [33:0] p;
		logic [31:0] p32;
		logic [40:0] s;
		logic [15:0] lo;
		logic w, ov;
		xd = xu ? {1'b0, d} : {d[15], d};
		xc = cu ? {1'b0, c} : {c[15], c};
		p = xd * xc;
		p32 = cf[0] ? {p[30:0], 1'b0} : p[31:0];
		if (cf[0] && cf[1] && !xu && !cu && d == DMC_MIN_OPERAND && c == DMC_MIN_OPERAND)
			p32 = DMC_MUL_SAT_VAL;
		if (sh)
			a = {{16{a[39]}}, a[39:16]};
		s = {a[39], a} + {{9{p32[31]}}, p32};
		if (rd_en) begin
			lo = s[15:0];
			s = s + DMC_ROUND_ADD;
			if (cf[2] && lo == 16'h8000)
				s[16] = 1'b0;
			s[15:0] = 16'h0;
		end
		w = cf[3] | wide;
		ov = w ? (s[40] != s[39]) : !(s[40:31] == 10'h0 || s[40:31] == 10'h3ff);
		if (ov && cf[4])
			s[39:0] = w ? (s[40] ? DMC_SAT40_NEG : DMC_SAT40_POS)
				: (s[40] ? DMC_SAT32_NEG : DMC_SAT32_POS);
		return {ov, s[39:0]};
	endfunction : ref_mac
	task automatic test_done();
		if (err_count == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : test_done
	task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] y);
		checks_done++;
		if (y !== x) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", nm, x, y);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		q = prdata;
		e = pslverr;
		if (pready !== 1'b1) begin
			err_count++;
			test_done();
		end
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	task automatic rd(input logic [7:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0);
		chk("prdata", x, q);
	endtask : rd
	initial begin
		{presetn, psel, penable, pwrite, cv, ud, uc, rn, wd, ef1, ef2} = '0;
		{paddr, pwdata, cvar, ea, dw} = '0;
		seed = 32'h0000_9a46;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(DMC_CTRL_OFF, 32'h0);
		rd(DMC_ACC2_HI_OFF, 32'h0);
		apb(1'b0, 8'h1c, 32'h0);
		chk("pslverr", 32'h1, {31'h0, e});
		for (i = 0; i < 60; i++) begin
			r = rnd();
			ct = (i == 0) ? 5'h03 : (i == 1) ? 5'h04 : r[4:0];
			dv = (i == 0) ? DMC_MIN_OPERAND : (i == 1) ? 16'h0000 : r[31:16];
			dw <= dv;
			apb(1'b1, DMC_CTRL_OFF, {27'h0, ct});
			r = rnd();
			e1 = {r[7:0], rnd()};
			e2 = {r[15:8], rnd()};
			if (i == 1)
				{e1[15:0], e2[15:0]} = 32'h8000_8000;
			apb(1'b1, DMC_ACC1_LO_OFF, e1[31:0]);
			apb(1'b1, DMC_ACC1_HI_OFF, {24'h0, e1[39:32]});
			apb(1'b1, DMC_ACC2_LO_OFF, e2[31:0]);
			apb(1'b1, DMC_ACC2_HI_OFF, {24'h0, e2[39:32]});
			apb(1'b1, DMC_OPCOUNT_OFF, 32'h0);
			for (k = 0; k < 16; k++) begin
				r = rnd();
				pm.mem[k] = (i == 0 || r[3:0] == 4'h0) ? DMC_MIN_OPERAND : r[31:16];
			end
			for (k = 0; k < 1 + i % 2; k++) begin
				r = rnd();
				if (i == 0)
					r[3:2] = 2'b00;
				if (i == 1 && k == 0)
					{r[7:6], r[4]} = 3'b001;
				cv <= 1'b1;
				cvar <= r[7:6];
				ud <= r[2];
				uc <= r[3];
				rn <= r[4];
				wd <= r[5];
				ea <= r[31:8];
				r2 = ref_mac(e2, dv, pm.mem[r[11:8]], r[2], r[3], r[7:6] == 2'b10, r[4], r[5], ct);
				r1 = ref_mac(e1, dv, pm.mem[r[11:8] ^ 4'h1], r[2], r[3],
					r[7:6] == 2'b01 || r[7:6] == 2'b10, r[4], r[5], ct);
				{e1, e2} = {r1[39:0], r2[39:0]};
				ef1 |= r1[40];
				ef2 |= r2[40];
				@(posedge pclk);
			end
			cv <= 1'b0;
			k = 0;
			while (mac_done !== 1'b1 && k < 10) begin
				@(posedge pclk);
				k++;
			end
			if (mac_done !== 1'b1) begin
				err_count++;
				test_done();
			end
			@(posedge pclk);
			rd(DMC_ACC1_LO_OFF, e1[31:0]);
			rd(DMC_ACC1_HI_OFF, {24'h0, e1[39:32]});
			rd(DMC_ACC2_LO_OFF, e2[31:0]);
			rd(DMC_ACC2_HI_OFF, {24'h0, e2[39:32]});
			rd(DMC_STATUS_OFF, {30'h0, ef2, ef1});
			chk("flags", {30'h0, ef2, ef1}, {30'h0, f2, f1});
			rd(DMC_CTRL_OFF, {27'h0, ct});
			rd(DMC_OPCOUNT_OFF, 1 + i % 2);
			apb(1'b1, DMC_STATUS_OFF, 32'h3);
			{ef1, ef2} = 2'b00;
		end
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(DMC_ACC1_LO_OFF, 32'h0);
		rd(DMC_CTRL_OFF, 32'h0);
		test_done();
	end
endmodule : testbench
